// File: design/fsr_top.sv
/*
 Settings reply formatter and power-up pin setup, with a Wishbone slave
 holding the stored settings. Assumes synchronous pin and status inputs
 and a host path that takes reply bytes under valid/ready.
*/
`include "fsr_consts.svh"
`default_nettype none
module fsr_top (
  input wire logic clk_i, // 50 MHz clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Write
  input wire logic [5:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic read_req_i, // Settings read request pulse
  input wire logic read_gp_i, // 1: pin settings reply, 0: chip settings
  input wire logic rpt_ready_i, // Host takes reply byte
  output fsr_pkg::fsr_rpt_s rpt_o, // Reply byte stream
  input wire logic [2:0] pin_in_i, // Pin levels
  output logic [2:0] pin_out_o, // Pin drive level
  output logic [2:0] pin_oe_o, // Pin drive enable
  input wire logic suspend_i, // Device suspended
  input wire logic rx_act_i, // Receive activity
  input wire logic tx_act_i, // Transmit activity
  input wire logic enum_done_i, // Enumeration completed
  output logic edge_flag_o, // Edge detection flag
  output logic [3:0] adc_ref_o, // One-hot: off, 1.024, 2.048, 4.096 V
  output logic dac_ref_supply_o, // 1: supply reference, 0: internal module
  output logic [15:0] vid_o, // Vendor identifier
  output logic [15:0] pid_o, // Product identifier
  output logic [7:0] usb_attr_o, // Power attributes
  output logic [8:0] max_ma_o, // Maximum current in mA
  output fsr_pkg::fsr_fn_e [2:0] pin_fn_o // Active pin functions
);
  import fsr_pkg::*;

  fsr_chip7_s chip7_q;
  logic [15:0] vid_q;
  logic [15:0] pid_q;
  logic [7:0] attr_q;
  logic [7:0] ma_q;
  fsr_pin_s [2:0] pins_q;
  logic [11:0] misc_q;
  logic apply_q;
  logic clr_d;
  logic edge_q;
  logic edge_prev_q;
  logic [4:0] div_cnt_q;
  logic clk_out_q;
  fsr_fn_e [2:0] fn_q;
  logic [2:0] gpio_val_q;
  logic [2:0] gpio_in_q;
  fsr_state_e state_q;
  logic sel_gp_q;
  logic [5:0] idx_q;
  logic bus_req;
  logic bus_wr;

  // Merge a write into a register under the byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Pin designation decode; unknown codes keep the previous function
  function automatic fsr_fn_e decode_fn(input int pin, input logic [2:0] code,
                                        input fsr_fn_e prev);
    fsr_fn_e f;
    f = prev;
    unique case (pin)
      0: begin
        unique case (code)
          3'h0: f = FN_GPIO;
          3'h1: f = FN_SUSPEND;
          3'h2: f = FN_RX_LED;
          default: f = prev;
        endcase
      end
      1: begin
        unique case (code)
          3'h0: f = FN_GPIO;
          3'h1: f = FN_CLKOUT;
          3'h2: f = FN_ADC;
          3'h3: f = FN_TX_LED;
          3'h4: f = FN_EDGE;
          default: f = prev;
        endcase
      end
      default: begin
        unique case (code)
          3'h0: f = FN_GPIO;
          3'h1: f = FN_CFG;
          3'h2: f = FN_ADC;
          3'h3: f = FN_DAC;
          default: f = prev;
        endcase
      end
    endcase
    return f;
  endfunction

  // Byte of the 64-byte reply at an index
  function automatic logic [7:0] reply_byte(input logic gp, input logic [5:0] idx,
                                            input fsr_chip7_s c7, input logic [15:0] vid,
                                            input logic [15:0] pid, input logic [7:0] attr,
                                            input logic [7:0] ma, input fsr_pin_s [2:0] pins,
                                            input logic [11:0] misc);
    logic [7:0] b;
    b = `FSR_ZERO8;
    unique case (idx)
      6'h00: b = `FSR_CMD_ECHO;
      6'h01: b = `FSR_OK;
      6'h02: b = gp ? `FSR_GP_LEN : `FSR_CHIP_LEN;
      6'h04: b = gp ? pins[0] : {1'b0, misc[10], misc[11], 1'b0, misc[9], misc[8], 2'b00};
      6'h05: b = gp ? pins[1] : {3'b000, misc[4:0]};
      6'h06: b = gp ? pins[2] : `FSR_ZERO8;
      6'h07: b = gp ? `FSR_ZERO8 : {1'b0, c7[6:2], 2'b00};
      6'h08: b = gp ? `FSR_ZERO8 : vid[7:0];
      6'h09: b = gp ? `FSR_ZERO8 : vid[15:8];
      6'h0A: b = gp ? `FSR_ZERO8 : pid[7:0];
      6'h0B: b = gp ? `FSR_ZERO8 : pid[15:8];
      6'h0C: b = gp ? `FSR_ZERO8 : attr;
      6'h0D: b = gp ? `FSR_ZERO8 : ma;
      default: b = `FSR_ZERO8;
    endcase
    return b;
  endfunction

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i;

  // Bus acknowledge, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req) begin
      unique case (wb_adr_i)
        `FSR_ADR_CHIP7: wb_dat_o <= {24'h000000, chip7_q};
        `FSR_ADR_IDS: wb_dat_o <= {pid_q, vid_q};
        `FSR_ADR_POWER: wb_dat_o <= {16'h0000, ma_q, attr_q};
        `FSR_ADR_PINS: wb_dat_o <= {8'h00, pins_q};
        `FSR_ADR_MISC: wb_dat_o <= {20'h00000, misc_q};
        `FSR_ADR_STAT: wb_dat_o <= {24'h000000, pin_in_i, state_q, 3'h0, edge_q};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Stored settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chip7_q <= `FSR_RST_CHIP7;
      vid_q <= `FSR_RST_VID; // Arbitrary value
      pid_q <= `FSR_RST_PID; // Arbitrary value
      attr_q <= `FSR_RST_ATTR;
      ma_q <= `FSR_RST_MA;
      pins_q <= {`FSR_RST_PIN, `FSR_RST_PIN, `FSR_RST_PIN};
      misc_q <= `FSR_RST_MISC;
    end else if (bus_wr) begin
      unique case (wb_adr_i)
        `FSR_ADR_CHIP7: chip7_q <= 8'(merge({24'h0, chip7_q}, wb_dat_i, wb_sel_i));
        `FSR_ADR_IDS: {pid_q, vid_q} <= merge({pid_q, vid_q}, wb_dat_i, wb_sel_i);
        `FSR_ADR_POWER: {ma_q, attr_q} <= 16'(merge({16'h0, ma_q, attr_q}, wb_dat_i, wb_sel_i));
        `FSR_ADR_PINS: pins_q <= 24'(merge({8'h0, pins_q}, wb_dat_i, wb_sel_i));
        `FSR_ADR_MISC: misc_q <= 12'(merge({20'h0, misc_q}, wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // Apply request: after reset and on software command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      apply_q <= 1'b1;
    end else begin
      apply_q <= bus_wr && wb_adr_i == `FSR_ADR_CTRL && wb_sel_i[0] && wb_dat_i[`FSR_CTRL_APPLY];
    end
  end

  assign clr_d = bus_wr && wb_adr_i == `FSR_ADR_CTRL && wb_sel_i[0] && wb_dat_i[`FSR_CTRL_CLR];

  // Pin function, direction and level applied from the stored bytes
  for (genvar p = 0; p < 3; p++) begin : g_pin
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        fn_q[p] <= FN_GPIO;
        gpio_val_q[p] <= 1'b0;
        gpio_in_q[p] <= 1'b1;
      end else if (apply_q) begin
        fn_q[p] <= decode_fn(p, pins_q[p].desig, fn_q[p]);
        gpio_val_q[p] <= pins_q[p].out_val;
        gpio_in_q[p] <= pins_q[p].dir_in;
      end
    end
  end

  // Edge detect on pin one; set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_prev_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      edge_prev_q <= pin_in_i[1];
      if (fn_q[1] == FN_EDGE && chip7_q.fall_en && edge_prev_q && !pin_in_i[1]) begin
        edge_q <= 1'b1;
      end else if (fn_q[1] == FN_EDGE && chip7_q.rise_en && !edge_prev_q && pin_in_i[1]) begin
        edge_q <= 1'b1;
      end else if (clr_d) begin
        edge_q <= 1'b0;
      end
    end
  end

  // Clock output divider, zero treated as one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_q <= 5'h00;
      clk_out_q <= 1'b0;
    end else if (div_cnt_q + 5'h01 >= misc_q[4:0]) begin
      div_cnt_q <= 5'h00;
      clk_out_q <= !clk_out_q;
    end else begin
      div_cnt_q <= div_cnt_q + 5'h01;
    end
  end

  // Pin drive per function
  for (genvar p = 0; p < 3; p++) begin : g_drive
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pin_out_o[p] <= 1'b0;
        pin_oe_o[p] <= 1'b0;
      end else begin
        unique case (fn_q[p])
          FN_GPIO: begin
            pin_out_o[p] <= gpio_val_q[p];
            pin_oe_o[p] <= !gpio_in_q[p];
          end
          FN_SUSPEND: begin
            pin_out_o[p] <= misc_q[9] ^ suspend_i;
            pin_oe_o[p] <= 1'b1;
          end
          FN_RX_LED: begin
            pin_out_o[p] <= misc_q[10] ^ rx_act_i;
            pin_oe_o[p] <= 1'b1;
          end
          FN_TX_LED: begin
            pin_out_o[p] <= misc_q[11] ^ tx_act_i;
            pin_oe_o[p] <= 1'b1;
          end
          FN_CLKOUT: begin
            pin_out_o[p] <= clk_out_q;
            pin_oe_o[p] <= 1'b1;
          end
          FN_CFG: begin
            pin_out_o[p] <= misc_q[8] ^ enum_done_i;
            pin_oe_o[p] <= 1'b1;
          end
          default: begin
            pin_out_o[p] <= 1'b0;
            pin_oe_o[p] <= 1'b0;
          end
        endcase
      end
    end
  end

  // Settings handed to the converters and enumeration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_ref_o <= 4'h1;
      dac_ref_supply_o <= 1'b0;
      vid_o <= 16'h0000;
      pid_o <= 16'h0000;
      usb_attr_o <= 8'h00;
      max_ma_o <= 9'h000;
    end else begin
      adc_ref_o <= 4'(4'h1 << chip7_q.adc_ref);
      dac_ref_supply_o <= chip7_q.dac_supply;
      vid_o <= vid_q;
      pid_o <= pid_q;
      usb_attr_o <= attr_q;
      max_ma_o <= {ma_q, 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_flag_o <= 1'b0;
      pin_fn_o <= '{FN_GPIO, FN_GPIO, FN_GPIO};
    end else begin
      edge_flag_o <= edge_q;
      pin_fn_o <= fn_q;
    end
  end

  // Reply sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      sel_gp_q <= 1'b0;
      idx_q <= 6'h00;
      rpt_o <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (read_req_i) begin
            state_q <= ST_SEND;
            sel_gp_q <= read_gp_i;
            idx_q <= 6'h00;
            rpt_o <= '{valid: 1'b1, last: 1'b0, index: 6'h00,
                       data: reply_byte(read_gp_i, 6'h00, chip7_q, vid_q, pid_q, attr_q,
                                        ma_q, pins_q, misc_q)};
          end
        end
        ST_SEND: begin
          if (rpt_ready_i) begin
            if (idx_q == `FSR_IDX_LAST) begin
              state_q <= ST_IDLE;
              rpt_o <= '0;
            end else begin
              idx_q <= idx_q + 6'h01;
              rpt_o <= '{valid: 1'b1, last: (idx_q + 6'h01) == `FSR_IDX_LAST,
                         index: idx_q + 6'h01,
                         data: reply_byte(sel_gp_q, idx_q + 6'h01, chip7_q, vid_q, pid_q,
                                          attr_q, ma_q, pins_q, misc_q)};
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: design/fsr_consts.svh
/*
 Constants of the settings reply and pin setup block: offsets, fields,
 reset values and reply codes. Assumes a 32-bit classic Wishbone bus.
*/
// Operation
// - Reply byte 0 echoes the read command, byte 1 carries the success code.
// - Falling-edge enable set: high-to-low on edge input sets the edge flag.
// - Rising-edge enable set: low-to-high on edge input sets the edge flag.
// - Converter reference field: 11 4.096V, 10 2.048V, 01 1.024V, 00 off.
// - Output-converter reference bit: one supply-derived, zero internal reference module.
// - Vendor identifier low byte at index 8, high byte at index 9.
// - Product identifier low byte at index 10, high byte at index 11.
// - Stored byte 12 becomes the power attributes used at enumeration.
// - Reported maximum bus current is twice stored byte 13, in mA.
// - Pin bytes at indices 4-6; output pins drive bit 4 after reset.
// - Bit 3 one makes a general-purpose pin input, zero output.
// - Pin zero codes: 000 general, 001 suspend, 010 receive activity; rest ignored.
// - Pin one: 000 general, 001 clock, 010 converter, 011 transmit, 100 edge.
// - Ignored codes (pin one 101-111, pin two 100-111) leave function unchanged.
// - Pin two: 000 general, 001 configured, 010 converter two, 011 analog out.
// - Configured indicator shows idle level, inverted once enumeration completes.
// - Clock output pin drives the clock divided by the five-bit setting; the code toggles it every setting cycles, dividing by twice the setting.
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH
`define FSR_ADR_CHIP7 6'h00
`define FSR_ADR_IDS 6'h04
`define FSR_ADR_POWER 6'h08
`define FSR_ADR_PINS 6'h0C
`define FSR_ADR_MISC 6'h10
`define FSR_ADR_CTRL 6'h14
`define FSR_ADR_STAT 6'h18
`define FSR_CTRL_APPLY 0
`define FSR_CTRL_CLR 1
`define FSR_RST_CHIP7 8'h00
`define FSR_RST_VID 16'h1234
`define FSR_RST_PID 16'h5678
`define FSR_RST_ATTR 8'h80
`define FSR_RST_MA 8'h32
`define FSR_RST_PIN 8'h08
`define FSR_RST_MISC 12'h001
`define FSR_CMD_ECHO 8'hB0
`define FSR_OK 8'h00
`define FSR_CHIP_LEN 8'h0E
`define FSR_GP_LEN 8'h08
`define FSR_IDX_LAST 6'h3F
`define FSR_ZERO8 8'h00
`endif

// File: design/fsr_pkg.sv
/*
 Types of the settings reply and pin setup block.
 Assumes fsr_consts.svh supplies the numeric constants.
*/
`default_nettype none
package fsr_pkg;
  typedef struct packed {
    logic [2:0] spare;
    logic out_val;
    logic dir_in;
    logic [2:0] desig;
  } fsr_pin_s;
  typedef struct packed {
    logic spare7;
    logic fall_en;
    logic rise_en;
    logic [1:0] adc_ref;
    logic dac_supply;
    logic [1:0] spare;
  } fsr_chip7_s;
  typedef struct packed {
    logic valid;
    logic last;
    logic [5:0] index;
    logic [7:0] data;
  } fsr_rpt_s;
  typedef enum logic [3:0] {
    FN_GPIO, FN_SUSPEND, FN_RX_LED, FN_CLKOUT, FN_ADC,
    FN_TX_LED, FN_EDGE, FN_CFG, FN_DAC
  } fsr_fn_e;
  typedef enum logic {ST_IDLE, ST_SEND} fsr_state_e;
endpackage
`default_nettype wire

// File: test/fsr_checker.sv
/*
 Assertion checker for the settings reply and pin setup block.
 Bound to fsr_top; sees only its ports.
*/
`default_nettype none
module fsr_checker (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Write
  input wire logic [5:0] wb_adr_i, // Address
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic read_req_i, // Reply request
  input wire logic read_gp_i, // Pin reply select
  input wire logic rpt_ready_i, // Host ready
  input wire fsr_pkg::fsr_rpt_s rpt_o, // Reply stream
  input wire logic edge_flag_o, // Edge flag
  input wire logic [3:0] adc_ref_o, // Converter reference
  input wire logic [15:0] vid_o, // Vendor id
  input wire logic [15:0] pid_o, // Product id
  input wire logic [7:0] usb_attr_o, // Power attributes
  input wire logic [8:0] max_ma_o // Current in mA
);
  import fsr_pkg::*;
  logic gp_q;
  logic clr_w;
  // Clear request on the control register
  assign clr_w = wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == 6'h14) & wb_dat_i[1];
  always_ff @(posedge clk_i) begin
    if (read_req_i && !rpt_o.valid) begin
      gp_q <= read_gp_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    rpt_o.valid && rpt_ready_i && !rpt_o.last;
  endsequence
  sequence s_next;
    rpt_o.valid && rpt_o.index == $past(rpt_o.index) + 6'h01;
  endsequence
  echo_first_a: assert property ($rose(rpt_o.valid) |-> rpt_o.index == 6'h00 && rpt_o.data == 8'hB0)
    else $error("reply does not open with the echo");
  ok_code_a: assert property (rpt_o.valid && rpt_o.index == 6'h01 |-> rpt_o.data == 8'h00)
    else $error("reply status byte wrong");
  index_step_a: assert property (s_take |=> s_next)
    else $error("reply index did not advance by one");
  last_flag_a: assert property (rpt_o.valid && rpt_o.index == 6'h3F |-> rpt_o.last)
    else $error("last not marked on final byte");
  tail_zero_a: assert property (rpt_o.valid && rpt_o.index > 6'h0D |-> rpt_o.data == 8'h00)
    else $error("tail byte not zero");
  vid_place_a: assert property (rpt_o.valid && !gp_q && rpt_o.index[5:1] == 5'h04
    |-> rpt_o.data == (rpt_o.index[0] ? vid_o[15:8] : vid_o[7:0]))
    else $error("vendor id byte misplaced");
  pid_place_a: assert property (rpt_o.valid && !gp_q && rpt_o.index[5:1] == 5'h05
    |-> rpt_o.data == (rpt_o.index[0] ? pid_o[15:8] : pid_o[7:0]))
    else $error("product id byte misplaced");
  attr_byte_a: assert property (rpt_o.valid && !gp_q && rpt_o.index == 6'h0C
    |-> rpt_o.data == usb_attr_o)
    else $error("power attributes differ from reply");
  twice_ma_a: assert property (rpt_o.valid && !gp_q && rpt_o.index == 6'h0D
    |-> max_ma_o == {rpt_o.data, 1'h0})
    else $error("current is not twice the stored byte");
  ref_onehot_a: assert property ($onehot(adc_ref_o))
    else $error("converter reference not one-hot");
  edge_hold_a: assert property (edge_flag_o && !clr_w && !$past(clr_w) |=> edge_flag_o)
    else $error("edge flag dropped without a clear");
endmodule
bind fsr_top fsr_checker i_fsr_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
  .read_req_i, .read_gp_i, .rpt_ready_i, .rpt_o, .edge_flag_o, .adc_ref_o, .vid_o, .pid_o, .usb_attr_o, .max_ma_o);
`default_nettype wire

// File: test/fsr_host_model.sv
/*
 Host model: asks for a settings reply and collects its bytes.
 Assumes the valid/ready reply stream of fsr_top.
*/
`default_nettype none
module fsr_host_model (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic start_i, // Begin a request
  input wire logic slow_i, // Stall every other cycle
  input wire fsr_pkg::fsr_rpt_s rpt_i, // Reply stream
  output logic read_req_o, // Request pulse
  output logic ready_o, // Takes the byte
  output logic done_o // Last byte taken
);
  import fsr_pkg::*;
  logic [7:0] got_q [64];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_req_o <= 1'h0;
      ready_o <= 1'h0;
      done_o <= 1'h0;
    end else begin
      read_req_o <= start_i;
      ready_o <= slow_i ? !ready_o : 1'h1;
      if (start_i) begin
        done_o <= 1'h0;
      end
      if (rpt_i.valid && ready_o) begin
        got_q[rpt_i.index] <= rpt_i.data;
        done_o <= rpt_i.last;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/tb_top.sv
/*
 Self-checking bench for fsr_top.
 Assumes the checker is bound and the host model drives the reply handshake.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fsr_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, read_req_i, read_gp_i, rpt_ready_i, enum_done_i;
  logic edge_flag_o, dac_ref_supply_o, start, slow, done;
  logic suspend_i, rx_act_i, tx_act_i;
  logic [5:0] wb_adr_i;
  logic [3:0] wb_sel_i, adc_ref_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [2:0] pin_in_i, pin_out_o, pin_oe_o;
  logic [15:0] vid_o, pid_o;
  logic [7:0] usb_attr_o;
  logic [8:0] max_ma_o;
  logic [7:0] exp_b [64];
  fsr_rpt_s rpt_o;
  fsr_fn_e [2:0] pin_fn_o;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  fsr_top i_fsr_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .read_req_i, .read_gp_i, .rpt_ready_i, .rpt_o, .pin_in_i, .pin_out_o, .pin_oe_o, .suspend_i,
    .rx_act_i, .tx_act_i, .enum_done_i, .edge_flag_o, .adc_ref_o, .dac_ref_supply_o, .vid_o, .pid_o,
    .usb_attr_o, .max_ma_o, .pin_fn_o);
  fsr_host_model i_fsr_host_model (.clk_i, .rst_i, .start_i(start), .slow_i(slow), .rpt_i(rpt_o),
    .read_req_o(read_req_i), .ready_o(rpt_ready_i), .done_o(done));
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end
  task close_out();
    $display("tests=%0d fails=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task rchk(input logic [5:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  task reply(input logic gp, input logic s);
    @(posedge clk_i);
    {read_gp_i, slow, start} <= {gp, s, 1'h1};
    @(posedge clk_i);
    start <= 1'h0;
    do begin
      @(posedge clk_i);
    end while (done !== 1'h1);
    for (int i = 0; i < 64; i++) chk(i_fsr_host_model.got_q[i], exp_b[i]);
  endtask
  task t_reset();
    rchk(6'h04, 32'h56781234);
    rchk(6'h08, 32'h3280);
    rchk(6'h0C, 32'h080808);
    wb(1'h1, 6'h18, 32'hFFFFFFFF);
    rchk(6'h18, 32'h0);
    rchk(6'h1C, 32'h0);
    chk(adc_ref_o, 4'h1);
    chk(max_ma_o, 9'h064);
    chk(pin_oe_o, 3'h0);
    chk(vid_o, 16'h1234);
    chk(pid_o, 16'h5678);
    $display("t_reset done");
  endtask
  task t_chip();
    for (int c = 0; c < 4; c++) begin
      wb(1'h1, 6'h00, {27'h0, c[1:0], c[0], 2'h0});
      wait_n(2);
      chk(adc_ref_o, 4'h1 << c);
      chk(dac_ref_supply_o, c[0]);
    end
    wb(1'h1, 6'h04, 32'hBEEFCAFE);
    wb(1'h1, 6'h08, 32'hFA40);
    wait_n(2);
    chk(max_ma_o, 9'h1F4);
    chk(usb_attr_o, 8'h40);
    chk(vid_o, 16'hCAFE);
    chk(pid_o, 16'hBEEF);
    exp_b = '{0: 8'hB0, 2: 8'h0E, 5: 8'h01, 7: 8'h1C, 8: 8'hFE, 9: 8'hCA, 10: 8'hEF, 11: 8'hBE, 12: 8'h40,
      13: 8'hFA, default: 8'h00};
    reply(1'h0, 1'h1);
    $display("t_chip done");
  endtask
  task automatic t_pins();
    fsr_fn_e f0 [3] = '{FN_GPIO, FN_SUSPEND, FN_RX_LED};
    fsr_fn_e f1 [5] = '{FN_GPIO, FN_CLKOUT, FN_ADC, FN_TX_LED, FN_EDGE};
    fsr_fn_e f2 [4] = '{FN_GPIO, FN_CFG, FN_ADC, FN_DAC};
    wb(1'h1, 6'h0C, 32'h101000);
    wb(1'h1, 6'h14, 32'h1);
    wait_n(3);
    chk(pin_oe_o, 3'h7);
    chk(pin_out_o, 3'h6);
    for (int i = 0; i < 8; i++) begin
      wb(1'h1, 6'h0C, {8'h0, 5'h01, i[2:0], 5'h01, i[2:0], 5'h01, i[2:0]});
      wb(1'h1, 6'h14, 32'h1);
      wait_n(3);
      chk(pin_fn_o, {f2[i > 3 ? 3 : i], f1[i > 4 ? 4 : i], f0[i > 2 ? 2 : i]});
    end
    exp_b = '{0: 8'hB0, 2: 8'h08, 4: 8'h0F, 5: 8'h0F, 6: 8'h0F, default: 8'h00};
    reply(1'h1, 1'h0);
    wb(1'h1, 6'h0C, 32'h090C0A);
    wb(1'h1, 6'h10, 32'h101);
    wb(1'h1, 6'h14, 32'h1);
    wait_n(3);
    chk(pin_out_o[2], 1'h1);
    enum_done_i <= 1'h1;
    wait_n(3);
    chk(pin_out_o[2], 1'h0);
    chk(pin_oe_o, 3'h5);
    chk(pin_out_o[0], 1'h0);
    rx_act_i <= 1'h1;
    wait_n(3);
    chk(pin_out_o[0], 1'h1);
    $display("t_pins done");
  endtask
  task automatic t_clk();
    int n = 0;
    logic p;
    wb(1'h1, 6'h10, 32'h203);
    wb(1'h1, 6'h0C, 32'h080101);
    wb(1'h1, 6'h14, 32'h1);
    wait_n(3);
    chk(pin_oe_o, 3'h3);
    chk(pin_out_o[0], 1'h1);
    suspend_i <= 1'h1;
    p = pin_out_o[1];
    // Divider of three: one toggle every three cycles
    repeat (24) begin
      @(posedge clk_i);
      if (pin_out_o[1] !== p) n++;
      p = pin_out_o[1];
    end
    chk(pin_out_o[0], 1'h0);
    chk(n, 8);
    $display("t_clk done");
  endtask
  task pin1(input logic v);
    @(posedge clk_i);
    pin_in_i <= {1'h0, v, 1'h0};
    wait_n(4);
  endtask
  task t_edge();
    wb(1'h1, 6'h00, 32'h40);
    pin1(1'h1);
    chk(edge_flag_o, 1'h0);
    pin1(1'h0);
    chk(edge_flag_o, 1'h1);
    rchk(6'h18, 32'h1);
    wb(1'h1, 6'h14, 32'h2);
    wait_n(2);
    chk(edge_flag_o, 1'h0);
    wb(1'h1, 6'h00, 32'h20);
    pin1(1'h1);
    chk(edge_flag_o, 1'h1);
    wb(1'h1, 6'h00, 32'h0);
    wait_n(3);
    chk(edge_flag_o, 1'h1);
    $display("t_edge done");
  endtask
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, start, slow, read_gp_i, enum_done_i, suspend_i, rx_act_i, tx_act_i} = 10'h000;
    wb_adr_i = 6'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    pin_in_i = 3'h0;
    rst_i = 1'h1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_chip();
    t_pins();
    t_edge();
    t_clk();
    close_out();
  end
endmodule
`default_nettype wire
